// ===== logic/lvds_test_pattern.sv
`timescale 1ns/100ps
// Operation
// - ramp replaces data, steps one LSB per conversion, starts at negative full-scale
// - after positive full-scale the ramp wraps to negative full-scale
// - serialized ramp step is two to the power (S minus N)
// - toggle alternates all-ones and all-zeros words each conversion
// - toggle start word may be zeros or ones; receiver assumes neither
// - per-lane patterns only when per-lane enable is one, from own field
// - global random needs select, custom/ramp base, enable, type, sync reset
// - per-lane random only where that lane's random enable is set
// - frame lane takes patterns from its own field; random needs select too
// - trigger pulse or bit set-then-clear restarts ramp, toggle and random
// - amplifier partial power-down from fast pin or fast bit
// - converter partial power-down only from the fast pin
// - partial power-down keeps references and frame/clock buffers on
// - power-down entry completes in under two microseconds
// - full power-down from amplifier bit, converter bit or global pin
// - full power-down by the global pin switches everything off, references too
// - amplifier stage defaults to gain-compensation mode after reset
// - medium-power and low-power bits select the power level
module lvds_test_pattern
  import lvds_test_pkg::*;
#(
  parameter int N_BITS = ADC_BITS,
  parameter int S_BITS = SER_BITS,
  parameter int N_LANES = LANES
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic conv_clk,
  input wire logic [N_LANES*S_BITS-1:0] adc_data,
  input wire logic [S_BITS-1:0] frame_data,
  input wire logic [S_BITS-1:0] custom_pattern,
  input wire logic [PAT_W-1:0] global_pattern_select,
  input wire logic per_lane_pattern_enable,
  input wire logic [N_LANES*PAT_W-1:0] lane_pattern_select,
  input wire logic global_random_select,
  input wire logic random_generator_enable,
  input wire logic random_sequence_type,
  input wire logic random_generator_reset,
  input wire logic [N_LANES-1:0] lane_random_enable,
  input wire logic [PAT_W-1:0] frame_lane_pattern_select,
  input wire logic frame_lane_random_select,
  input wire logic transmit_trigger_pin,
  input wire logic pattern_restart_bit,
  input wire logic fast_powerdown_pin,
  input wire logic fast_powerdown_bit,
  input wire logic amp_global_powerdown_bit,
  input wire logic converter_global_powerdown_bit,
  input wire logic global_powerdown_pin,
  input wire logic medium_power_bit,
  input wire logic low_power_bit,
  input wire logic cw_mode_bit,
  output logic [N_LANES*S_BITS-1:0] serial_data_lane,
  output logic [S_BITS-1:0] frame_lane,
  output logic word_valid,
  output logic amp_partial_off,
  output logic adc_partial_off,
  output logic amp_full_off,
  output logic adc_full_off,
  output logic reference_on,
  output logic frame_buffer_on,
  output logic data_buffer_on,
  output logic tgc_mode,
  output logic [1:0] power_level
);

  initial
  begin
    if (S_BITS < N_BITS || N_BITS < 2)
      $error("lvds_test_pattern resolution wider than the serial word");
    if (S_BITS > 23)
      $error("lvds_test_pattern serial word wider than the random generator");
    if (N_LANES < 1)
      $error("lvds_test_pattern needs at least one lane");
  end

  // ****************************************
  // pin synchronisers and edge detection
  // ****************************************
  logic [3:0] pins_s;
  logic conv_d_r;
  logic trig_d_r;
  logic rbit_d_r;
  logic conv_edge;
  logic restart;

  pin_sync #(.W(4)) u_sync
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin_in({conv_clk, transmit_trigger_pin, fast_powerdown_pin, global_powerdown_pin}),
    .pin_out(pins_s)
  );

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      conv_d_r <= 1'b0;
    else
      conv_d_r <= pins_s[3];
  end

  // delays reset to the idle low level, so a release gives no false edge
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      trig_d_r <= 1'b0;
    else
      trig_d_r <= pins_s[2];
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      rbit_d_r <= 1'b0;
    else
      rbit_d_r <= pattern_restart_bit;
  end

  assign conv_edge = pins_s[3] & ~conv_d_r;
  // restart on rising trigger pulse or on the falling edge of the bit
  assign restart = (pins_s[2] & ~trig_d_r) | (rbit_d_r & ~pattern_restart_bit) | random_generator_reset;

  // ****************************************
  // ramp and toggle generators
  // ****************************************
  localparam logic [S_BITS-1:0] RAMP_STEP = S_BITS'(1) << (S_BITS - N_BITS);
  localparam logic [S_BITS-1:0] NEG_FULL = S_BITS'(1) << (S_BITS - 1);
  logic [S_BITS-1:0] ramp_r;
  logic toggle_r;

  // offset-binary ramp mapped to two's complement: negative full-scale first
  always_ff @(posedge clk_sys)
  begin
    if (rst || restart)
      ramp_r <= NEG_FULL;
    else if (conv_edge)
      ramp_r <= ramp_r + RAMP_STEP;
  end

  // start word after restart is zeros; the receiver must not rely on it
  always_ff @(posedge clk_sys)
  begin
    if (rst || restart)
      toggle_r <= 1'b0;
    else if (conv_edge)
      toggle_r <= ~toggle_r;
  end

  logic [S_BITS-1:0] prbs_word;

  // one generator shared by all lanes, so random lanes carry the same word
  prbs_gen #(.W(S_BITS)) u_prbs
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .restart(restart),
    .step(conv_edge && random_generator_enable),
    .seq_type(random_sequence_type),
    .word(prbs_word)
  );

  // ****************************************
  // pattern selection
  // ****************************************
  function automatic logic [S_BITS-1:0] pick
  (
    input logic [PAT_W-1:0] sel,
    input logic [S_BITS-1:0] raw,
    input logic [S_BITS-1:0] custom,
    input logic [S_BITS-1:0] ramp,
    input logic tog
  );
    logic [S_BITS-1:0] r;
    r = raw;
    case (sel)
      PAT_NORMAL: r = raw;
      PAT_ZEROS: r = '0;
      PAT_ONES: r = '1;
      PAT_DESKEW: r = S_BITS'({(S_BITS+1)/2{2'b01}});
      PAT_SYNC: r = ~('1 >> (S_BITS / 2));
      PAT_CUSTOM: r = custom;
      PAT_RAMP: r = ramp;
      PAT_TOGGLE: r = {S_BITS{tog}};
      default: r = raw;
    endcase
    return r;
  endfunction

  logic powered;
  assign powered = ~(amp_full_off | adc_full_off);

  genvar g;
  generate
    for (g = 0; g < N_LANES; g++)
    begin : lane
      logic [PAT_W-1:0] sel;
      logic rnd;
      logic base_ok;
      logic [S_BITS-1:0] word;
      // lane field only counts when the per-lane enable is set
      assign sel = per_lane_pattern_enable ? lane_pattern_select[g*PAT_W +: PAT_W] : global_pattern_select;
      assign base_ok = (sel == PAT_CUSTOM) || (sel == PAT_RAMP);
      assign rnd = random_generator_enable && base_ok &&
                   (per_lane_pattern_enable ? lane_random_enable[g] : global_random_select);
      assign word = rnd ? prbs_word : pick(sel, adc_data[g*S_BITS +: S_BITS], custom_pattern, ramp_r, toggle_r);
      // in converter partial power-down (fast pin) a lane keeps its last word rather than sending stale samples

      always_ff @(posedge clk_sys)
      begin
        if (rst)
          serial_data_lane[g*S_BITS +: S_BITS] <= '0;
        else if (conv_edge && powered && !adc_partial_off)
          serial_data_lane[g*S_BITS +: S_BITS] <= word;
      end
    end
  endgenerate

  // ****************************************
  // frame lane
  // ****************************************
  // random on the frame lane only over a custom or ramp base
  logic frame_rnd;
  assign frame_rnd = frame_lane_random_select && random_generator_enable &&
                     (frame_lane_pattern_select == PAT_CUSTOM || frame_lane_pattern_select == PAT_RAMP);

  // frame buffer survives partial power-down, so only full power-down stops it
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      frame_lane <= '0;
    else if (conv_edge && powered)
      frame_lane <= frame_rnd ? prbs_word :
                    pick(frame_lane_pattern_select, frame_data, custom_pattern, ramp_r, toggle_r);
  end

  // still pulses in partial power-down, while the data lanes hold under the fast pin only
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      word_valid <= 1'b0;
    else
      word_valid <= conv_edge && powered;
  end

  // ****************************************
  // power control
  // ****************************************
  // two synchroniser cycles plus one register: well under the entry limit
  logic fast_pin;
  logic gbl_pin;
  assign fast_pin = pins_s[1];
  assign gbl_pin = pins_s[0];

  // pins act two cycles after the register bits because of the synchroniser
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      amp_partial_off <= 1'b0;
    else
      amp_partial_off <= fast_pin | fast_powerdown_bit;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      adc_partial_off <= 1'b0;
    else
      adc_partial_off <= fast_pin;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      amp_full_off <= 1'b0;
    else
      amp_full_off <= amp_global_powerdown_bit | gbl_pin;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      adc_full_off <= 1'b0;
    else
      adc_full_off <= converter_global_powerdown_bit | gbl_pin;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      reference_on <= 1'b1;
    else
      reference_on <= ~(amp_global_powerdown_bit | converter_global_powerdown_bit | gbl_pin);
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      frame_buffer_on <= 1'b1;
    else
      frame_buffer_on <= ~(converter_global_powerdown_bit | gbl_pin);
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      data_buffer_on <= 1'b1;
    else
      data_buffer_on <= ~(converter_global_powerdown_bit | gbl_pin | fast_pin);
  end

  // ****************************************
  // amplifier mode and power level
  // ****************************************
  // continuous-wave mode is the only way out of gain compensation
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      tgc_mode <= 1'b1;
    else
      tgc_mode <= ~cw_mode_bit;
  end

  // low power wins when both bits are set
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      power_level <= PWR_NORMAL;
    else if (low_power_bit)
      power_level <= PWR_LOW;
    else if (medium_power_bit)
      power_level <= PWR_MEDIUM;
    else
      power_level <= PWR_NORMAL;
  end

endmodule

// ===== logic/lvds_test_pkg.sv
package lvds_test_pkg;

  // ****************************************
  // pattern codes and sizes
  // ****************************************
  localparam int ADC_BITS = 14;
  localparam int SER_BITS = 16;
  localparam int LANES = 4;
  localparam int PAT_W = 3;
  localparam logic [2:0] PAT_NORMAL = 3'h0;
  localparam logic [2:0] PAT_ZEROS = 3'h1;
  localparam logic [2:0] PAT_ONES = 3'h2;
  localparam logic [2:0] PAT_DESKEW = 3'h3;
  localparam logic [2:0] PAT_SYNC = 3'h4;
  localparam logic [2:0] PAT_CUSTOM = 3'h5;
  localparam logic [2:0] PAT_RAMP = 3'h6;
  localparam logic [2:0] PAT_TOGGLE = 3'h7;
  localparam logic SEQ_PRBS7 = 1'b0;
  localparam logic SEQ_PRBS23 = 1'b1;
  localparam logic [22:0] PRBS_SEED = 23'h7FFFFF;
  localparam logic [15:0] CUSTOM_RESET = 16'h0000;

  // ****************************************
  // power register positions and timing
  // ****************************************
  localparam int MEDIUM_POWER_BIT_REG = 206;
  localparam int MEDIUM_POWER_BIT_BIT = 14;
  localparam int LOW_POWER_BIT_REG = 200;
  localparam int LOW_POWER_BIT_BIT = 12;
  localparam int CLK_MHZ = 40;
  localparam int PDN_ENTRY_NS = 2000;
  localparam int PDN_ENTRY_CYC = PDN_ENTRY_NS * CLK_MHZ / 1000;
  localparam int WAKE_CLOCK_US = 50;

  typedef enum logic [1:0]
  {
    PWR_NORMAL = 2'h0,
    PWR_MEDIUM = 2'h1,
    PWR_LOW = 2'h2
  } power_level_e;

endpackage

// ===== logic/prbs_gen.sv
`timescale 1ns/100ps
module prbs_gen
  import lvds_test_pkg::*;
#(
  parameter int W = SER_BITS
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic restart,
  input wire logic step,
  input wire logic seq_type,
  output logic [W-1:0] word
);

  logic [22:0] lfsr_r;
  logic [22:0] lfsr_nxt;
  logic fb;

  initial
  begin
    if (W < 1 || W > 23)
      $error("prbs_gen width out of range");
  end

  // ****************************************
  // W shifts per word; word is the low bits
  // ****************************************
  always_comb
  begin
    lfsr_nxt = lfsr_r;
    fb = 1'b0;
    for (int i = 0; i < W; i++)
    begin
      if (seq_type == SEQ_PRBS23)
        fb = lfsr_nxt[22] ^ lfsr_nxt[17];
      else
        fb = lfsr_nxt[6] ^ lfsr_nxt[5];
      lfsr_nxt = {lfsr_nxt[21:0], fb};
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst || restart)
      lfsr_r <= PRBS_SEED;
    else if (step)
      lfsr_r <= lfsr_nxt;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      word <= '0;
    else
      word <= lfsr_r[W-1:0];
  end

endmodule

// ===== logic/pin_sync.sv
`timescale 1ns/100ps
module pin_sync
#(
  parameter int W = 1
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_out
);

  // ****************************************
  // two-stage synchroniser per bit
  // ****************************************
  logic [W-1:0] meta_r;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      meta_r <= '0;
      pin_out <= '0;
    end
    else
    begin
      meta_r <= pin_in;
      pin_out <= meta_r;
    end
  end

endmodule

// ===== bench/lvds_test_monitor.sv
`timescale 1ns/100ps
module lvds_test_monitor
  import lvds_test_pkg::*;
#(
  parameter int S_BITS = SER_BITS,
  parameter int N_LANES = LANES
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [N_LANES*S_BITS-1:0] adc_data,
  input wire logic [PAT_W-1:0] global_pattern_select,
  input wire logic per_lane_pattern_enable,
  input wire logic fast_powerdown_pin,
  input wire logic fast_powerdown_bit,
  input wire logic global_powerdown_pin,
  input wire logic converter_global_powerdown_bit,
  input wire logic amp_global_powerdown_bit,
  input wire logic medium_power_bit,
  input wire logic low_power_bit,
  input wire logic cw_mode_bit,
  input wire logic [N_LANES*S_BITS-1:0] serial_data_lane,
  input wire logic word_valid,
  input wire logic amp_partial_off,
  input wire logic adc_partial_off,
  input wire logic amp_full_off,
  input wire logic adc_full_off,
  input wire logic reference_on,
  input wire logic frame_buffer_on,
  input wire logic tgc_mode,
  input wire logic [1:0] power_level
);
  // ****************************************
  // port relations
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  AST_NORMAL_PASS: assert property (word_valid && $past(global_pattern_select) == PAT_NORMAL
    && !$past(per_lane_pattern_enable) |-> serial_data_lane == $past(adc_data)) else $error("lane data altered");
  AST_FAST_BIT: assert property (fast_powerdown_bit |=> amp_partial_off) else $error("amp not off");
  AST_ADC_PIN_ONLY: assert property ((!fast_powerdown_pin) [*4] |-> !adc_partial_off) else $error("adc off");
  AST_FAST_PIN: assert property (fast_powerdown_pin [*3] |=> adc_partial_off && amp_partial_off)
    else $error("fast pin ignored");
  AST_PARTIAL_KEEP: assert property (adc_partial_off && !adc_full_off && !amp_full_off
    |-> reference_on && frame_buffer_on) else $error("buffers off in partial mode");
  AST_GLOBAL_PIN: assert property (global_powerdown_pin [*3] |=> amp_full_off && adc_full_off && !reference_on)
    else $error("global pin ignored");
  AST_ADC_BIT: assert property (converter_global_powerdown_bit |=> adc_full_off && !frame_buffer_on)
    else $error("adc global bit ignored");
  AST_AMP_BIT: assert property (amp_global_powerdown_bit |=> amp_full_off) else $error("amp global bit ignored");
  AST_TGC_RESET: assert property ($past(rst) && !cw_mode_bit |-> tgc_mode) else $error("tgc mode lost");
  AST_LOW_POWER: assert property (low_power_bit |=> power_level == 2'h2) else $error("low power");
  AST_MED_POWER: assert property (medium_power_bit && !low_power_bit |=> power_level == 2'h1)
    else $error("medium power");
endmodule
bind lvds_test_pattern lvds_test_monitor #(.S_BITS(S_BITS), .N_LANES(N_LANES)) u_mon (.*);

// ===== bench/lane_receiver.sv
`timescale 1ns/100ps
module lane_receiver
  import lvds_test_pkg::*;
#(
  parameter int N_LANES = LANES
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [N_LANES*SER_BITS-1:0] serial_data_lane,
  input wire logic [SER_BITS-1:0] frame_lane,
  input wire logic word_valid,
  input wire logic adc_partial_off,
  output logic [N_LANES*SER_BITS-1:0] rx_lanes,
  output logic [SER_BITS-1:0] rx_frame,
  output logic [15:0] rx_count,
  output logic rx_lock
);
  // ****************************************
  // word capture
  // ****************************************
  // no start word is assumed, words are taken as they come
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      rx_count <= 16'h0;
    else if (word_valid)
    begin
      rx_lanes <= serial_data_lane;
      rx_frame <= frame_lane;
      rx_count <= rx_count + 16'h1;
    end
  end
  // alignment dropped on the fast power-down pin, regained on the next word
  always_ff @(posedge clk_sys)
    rx_lock <= (rst || adc_partial_off) ? 1'h0 : (word_valid ? 1'h1 : rx_lock);
endmodule

// ===== bench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import lvds_test_pkg::*;
  // short resolution keeps the full ramp wrap inside the run
  localparam int NB = 10;
  localparam logic [15:0] STEP = 16'h1 << (SER_BITS - NB);
  localparam logic [6:0] PE [5] = '{7'h47, 7'h66, 7'h18, 7'h08, 7'h10};
  localparam logic [6:0] PM [5] = '{7'h7F, 7'h7F, 7'h1F, 7'h1F, 7'h18};
  localparam logic [1:0] LV [4] = '{2'h0, 2'h1, 2'h2, 2'h2};
  logic clk_sys = 1'h0, rst = 1'h1, conv_clk = 1'h0;
  logic [63:0] adc_data = 64'h0, serial_data_lane, rx_lanes;
  logic [15:0] frame_data = 16'h0, custom_pattern = 16'h0, frame_lane, rx_frame, rx_count;
  logic [2:0] global_pattern_select = 3'h0, frame_lane_pattern_select = 3'h0;
  logic [11:0] lane_pattern_select = 12'h0;
  logic [3:0] lane_random_enable = 4'h0;
  logic [4:0] pd = 5'h0;
  logic per_lane_pattern_enable = 1'h0, global_random_select = 1'h0, random_generator_enable = 1'h0;
  logic random_sequence_type = 1'h0, random_generator_reset = 1'h0, frame_lane_random_select = 1'h0;
  logic transmit_trigger_pin = 1'h0, pattern_restart_bit = 1'h0, medium_power_bit = 1'h0, low_power_bit = 1'h0;
  logic cw_mode_bit = 1'h0, rx_lock;
  logic word_valid, amp_partial_off, adc_partial_off, amp_full_off, adc_full_off, reference_on;
  logic frame_buffer_on, data_buffer_on, tgc_mode;
  logic [1:0] power_level;
  wire [6:0] st = {amp_partial_off, adc_partial_off, amp_full_off, adc_full_off, reference_on, frame_buffer_on,
    data_buffer_on};
  int n_mismatch = 0, check_count = 0, cyc = 0;
  lvds_test_pattern #(.N_BITS(NB)) dut (.clk_sys, .rst, .conv_clk, .adc_data, .frame_data, .custom_pattern,
    .global_pattern_select, .per_lane_pattern_enable, .lane_pattern_select, .global_random_select,
    .random_generator_enable, .random_sequence_type, .random_generator_reset, .lane_random_enable,
    .frame_lane_pattern_select, .frame_lane_random_select, .transmit_trigger_pin, .pattern_restart_bit,
    .fast_powerdown_bit(pd[0]), .fast_powerdown_pin(pd[1]), .global_powerdown_pin(pd[2]),
    .converter_global_powerdown_bit(pd[3]), .amp_global_powerdown_bit(pd[4]), .medium_power_bit, .low_power_bit,
    .cw_mode_bit, .serial_data_lane, .frame_lane, .word_valid, .amp_partial_off, .adc_partial_off,
    .amp_full_off, .adc_full_off, .reference_on, .frame_buffer_on, .data_buffer_on, .tgc_mode, .power_level);
  lane_receiver rx (.clk_sys, .rst, .serial_data_lane, .frame_lane, .word_valid, .adc_partial_off, .rx_lanes,
    .rx_frame, .rx_count, .rx_lock);
  // ****************************************
  // clocks, timeout, helpers
  // ****************************************
  always #12.5 clk_sys = ~clk_sys;
  always #100 conv_clk = ~conv_clk;
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      summarize();
    end
  end
  task automatic summarize();
    $display("mismatches %0d of %0d checks", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // bounded wait for the receiver to take one more word
  task automatic w();
    logic [15:0] c;
    c = rx_count;
    for (int i = 0; i < 24 && rx_count === c; i++) @(posedge clk_sys) #1;
  endtask
  task automatic rs();
    @(posedge clk_sys) pattern_restart_bit <= 1'h1;
    @(posedge clk_sys) pattern_restart_bit <= 1'h0;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_ramp();
    @(posedge clk_sys) global_pattern_select <= PAT_RAMP;
    w();
    rs();
    for (int i = 0; i <= 1024; i++)
    begin
      w();
      chk(rx_lanes[15:0], 16'(16'h8000 + STEP * i));
    end
    chk(rx_lanes, {4{16'h8000}});
    @(posedge clk_sys) transmit_trigger_pin <= 1'h1;
    @(posedge clk_sys) transmit_trigger_pin <= 1'h0;
    w();
    chk(rx_lanes[15:0], 16'h8000);
    w();
    chk(rx_lanes[15:0], 16'h8000 + STEP);
  endtask
  task automatic t_toggle();
    logic [15:0] f;
    @(posedge clk_sys) global_pattern_select <= PAT_TOGGLE;
    w();
    rs();
    w();
    f = rx_lanes[15:0];
    chk(f === 16'h0 || f === 16'hFFFF, 64'h1);
    repeat (3)
    begin
      w();
      f = ~f;
      chk(rx_lanes, {4{f}});
    end
  endtask
  task automatic t_lanes();
    @(posedge clk_sys);
    per_lane_pattern_enable <= 1'h1;
    lane_pattern_select <= {PAT_NORMAL, PAT_CUSTOM, PAT_ZEROS, PAT_ONES};
    custom_pattern <= 16'hC35A;
    frame_lane_pattern_select <= PAT_CUSTOM;
    w();
    w();
    chk(rx_lanes, {adc_data[63:48], 16'hC35A, 16'h0, 16'hFFFF});
    chk(rx_frame, 16'hC35A);
    @(posedge clk_sys);
    per_lane_pattern_enable <= 1'h0;
    global_pattern_select <= PAT_ZEROS;
    frame_lane_pattern_select <= PAT_ONES;
    w();
    w();
    chk(rx_lanes, 64'h0);
    chk(rx_frame, 16'hFFFF);
  endtask
  task automatic t_random();
    logic [63:0] a;
    @(posedge clk_sys);
    global_pattern_select <= PAT_CUSTOM;
    frame_lane_pattern_select <= PAT_CUSTOM;
    {global_random_select, frame_lane_random_select, random_generator_enable} <= 3'h7;
    for (int k = 0; k < 3; k++)
    begin
      w();
      @(posedge clk_sys) random_generator_reset <= 1'h1;
      @(posedge clk_sys) random_generator_reset <= 1'h0;
      random_sequence_type <= (k == 2) ? SEQ_PRBS23 : SEQ_PRBS7;
      w();
      w();
      if (k == 0)
        a = rx_lanes;
      chk(rx_lanes === a, (k == 2) ? 64'h0 : 64'h1);
    end
    chk(a[15:0] !== 16'hC35A && rx_frame !== 16'hC35A, 64'h1);
    @(posedge clk_sys);
    per_lane_pattern_enable <= 1'h1;
    lane_pattern_select <= {4{PAT_CUSTOM}};
    lane_random_enable <= 4'h5;
    w();
    w();
    chk({rx_lanes[63:48], rx_lanes[31:16]}, {2{16'hC35A}});
    chk(rx_lanes[47:32] !== 16'hC35A && rx_lanes[15:0] !== 16'hC35A, 64'h1);
  endtask
  task automatic t_power();
    logic [15:0] c;
    logic [63:0] a;
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clk_sys) pd <= 5'h1 << i;
      tick(6);
      chk(st & PM[i], PE[i]);
      c = rx_count;
      a = rx_lanes;
      tick(20);
      chk(rx_count === c, i >= 2);
      chk(rx_lanes === a, i != 0);
      chk(rx_lock, i != 1);
      @(posedge clk_sys) pd <= 5'h0;
      tick(6);
      chk(st, 7'h07);
    end
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk_sys) {low_power_bit, medium_power_bit} <= 2'(i);
      tick(2);
      chk(power_level, LV[i]);
    end
    // second reset, taken while the continuous-wave bit is set
    @(posedge clk_sys) cw_mode_bit <= 1'h1;
    tick(2);
    chk(tgc_mode, 64'h0);
    rst <= 1'h1;
    tick(4);
    chk(tgc_mode, 64'h1);
    chk(st, 7'h07);
    rst <= 1'h0;
    cw_mode_bit <= 1'h0;
    w();
    w();
    chk({rx_lanes[63:48], rx_lanes[31:16]}, {2{16'hC35A}});
  endtask
  initial
  begin
    tick(4);
    rst <= 1'h0;
    @(posedge clk_sys) adc_data <= 64'h123456789ABCDEF0;
    frame_data <= 16'hA5C3;
    #1;
    chk(tgc_mode, 64'h1);
    w();
    w();
    chk(rx_lanes, 64'h123456789ABCDEF0);
    chk(rx_frame, 16'hA5C3);
    t_ramp();
    t_toggle();
    t_lanes();
    t_random();
    t_power();
    summarize();
  end
endmodule
